// file: core/qrs_pkg.sv
// Purpose: shared constants and carriers of the quasi-resonant switch timing block
// Assumes: 50 MHz core clock, comparator results arrive as digital levels
// Notes: times are kept in their own unit; cycle counts derive from them
package qrs_pkg;
   // ************************************************************
   // clock and timing
   // ************************************************************
   localparam int CLK_HZ = 50000000;
   localparam int CLK_NS = 1000000000 / CLK_HZ;
   // least times round up, longest times round down
   localparam int SW_BLANK_NS = 190;
   localparam int SW_BLANK_CYC = (SW_BLANK_NS + CLK_NS - 1) / CLK_NS;
   localparam int OVP_BLANK_US = 100;
   localparam int OVP_BLANK_CYC = (OVP_BLANK_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int MIN_FREQ_HZ = 20000;
   localparam int OFF_MAX_CYC = CLK_HZ / MIN_FREQ_HZ;
   localparam int LEB_NS = 220;
   localparam int LEB_CYC = (LEB_NS + CLK_NS - 1) / CLK_NS;
   localparam int ON_MAX_NS = 22000;
   localparam int ON_MAX_CYC = ON_MAX_NS / CLK_NS;
   localparam int SUP_SHORT_NS = 2500;
   localparam int SUP_SHORT_CYC = (SUP_SHORT_NS + CLK_NS - 1) / CLK_NS;
   localparam int SUP_LONG_NS = 5000;
   localparam int SUP_LONG_CYC = (SUP_LONG_NS + CLK_NS - 1) / CLK_NS;
   localparam int STEP_MS = 48;
   localparam int STEP_CYC = STEP_MS * (CLK_HZ / 1000);
   localparam int BEB_MS = 24;
   localparam int BEB_CYC = BEB_MS * (CLK_HZ / 1000);
   // ************************************************************
   // counters
   // ************************************************************
   localparam logic [2:0] VALLEY_MAX = 3'h7;
   localparam logic [2:0] VALLEY_MIN = 3'h0;
   localparam logic [2:0] SETPT_MIN = 3'h1;
   localparam logic [2:0] SETPT_MAX = 3'h7;
   localparam logic [2:0] BURST_SETPT = 3'h7;
   // ************************************************************
   // register map (byte addresses) and reset values
   // ************************************************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_MASK = 8'h08;
   localparam logic [7:0] REG_STATE = 8'h0c;
   localparam logic [7:0] REG_CL_BASE = 8'h10;
   localparam logic [7:0] REG_LINE_START = 8'h14;
   localparam logic [7:0] CL_BASE_RST = 8'hff;
   localparam logic [7:0] LINE_START_RST = 8'h40;
   localparam int CTRL_EN_BIT = 0;
   // status / mask bit positions
   localparam int EV_OVP = 0;
   localparam int EV_SW = 1;
   localparam int EV_BURST = 2;
   localparam int EV_OFFMAX = 3;
   localparam int EV_ONMAX = 4;
   localparam int EV_CLIMIT = 5;
   localparam int EV_W = 6;
   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic valley_below;   // sense below valley detect threshold
      logic ovp_above;      // sense above output overvoltage threshold
      logic sup_sel_above;  // sense above suppression select threshold
      logic pwm_trip;       // scaled current above feedback level
      logic climit_trip;    // current above line-adjusted limit
      logic sw_trip;        // current above shorted winding threshold
      logic fb_above_low;
      logic fb_above_high;
      logic fb_above_reset;
      logic fb_below_burst; // feedback below burst entry threshold
      logic burst_exit;     // feedback above burst leave threshold
      logic [7:0] line_code; // line-sense current, digitised
   } qrs_cmp_t;
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } qrs_bus_t;
endpackage : qrs_pkg

// file: core/qrs_switch_timing.sv
// Purpose: switch-on/off decision logic of a quasi-resonant flyback controller
// Assumes: comparator inputs are asynchronous levels; line code changes slowly
// Notes: one clock; ce low freezes every flip-flop
//
// Summary of operation
// R1 - valley counter saturates between 0 and 7, never wraps
// R2 - while off, each falling crossing below valley threshold adds one
// R3 - valley counter clears whenever the gate turns on
// R4 - overvoltage during off-time held past fixed blanking latches off
// R5 - low sense level selects long suppression, otherwise short suppression
// R6 - gate stays low for the whole suppression interval after turn-off
// R7 - after suppression, gate turns on when valley count reaches setpoint
// R8 - gate turns on after maximum off-time regardless, keeping the off-time within one 20 kHz period
// R9 - scaled current above feedback level turns the switch off
// R10 - pwm and current-limit comparators ignored during leading-edge blanking after turn-on
// R11 - gate forced off once on longer than maximum on-time
// R12 - current-limit trip after blanking turns gate off immediately
// R13 - shorted winding trip held past spike blanking latches off
// R14 - line current above start lowers the peak current limit by the excess
// R15 - burst set when feedback low, setpoint 7, held for 24 ms
// R16 - setpoint 1..7 steps every 48 ms from feedback thresholds
// R17 - setpoint forced to 1 on burst exit and at start-up
// R18 - comparators synchronised; intervals counted in clock cycles, configurable
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module qrs_switch_timing #(
   parameter int P_LEB = qrs_pkg::LEB_CYC,
   parameter int P_ON_MAX = qrs_pkg::ON_MAX_CYC,
   parameter int P_OFF_MAX = qrs_pkg::OFF_MAX_CYC,
   parameter int P_SUP_SHORT = qrs_pkg::SUP_SHORT_CYC,
   parameter int P_SUP_LONG = qrs_pkg::SUP_LONG_CYC,
   parameter int P_OVP_BLANK = qrs_pkg::OVP_BLANK_CYC,
   parameter int P_SW_BLANK = qrs_pkg::SW_BLANK_CYC,
   parameter int P_STEP = qrs_pkg::STEP_CYC,
   parameter int P_BEB = qrs_pkg::BEB_CYC
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // analog comparator results
   input wire qrs_pkg::qrs_cmp_t cmp_in,
   // register port
   input wire qrs_pkg::qrs_bus_t bus_in,
   output logic [31:0] rdata,
   output logic irq,
   // power stage
   output logic gate_drive_output,
   output logic [7:0] current_limit,
   output logic burst_active,
   output logic latched_off
);
   localparam int CW = 24;

   // ************************************************************
   // elaboration checks
   // ************************************************************
   if (P_OFF_MAX <= P_SUP_LONG || P_SUP_LONG < P_SUP_SHORT || P_SUP_SHORT < 1) begin : g_chk_sup
      $error("suppression intervals must be ordered and below maximum off-time");
   end
   if (P_ON_MAX <= P_LEB || P_LEB < 1 || P_STEP < 1 || P_BEB < 1) begin : g_chk_on
      $error("blanking must be shorter than maximum on-time");
   end
   if (P_STEP >= 2 ** CW || P_BEB >= 2 ** CW || P_OVP_BLANK >= 2 ** CW) begin : g_chk_w
      $error("interval too long for counter width");
   end

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      qrs_pkg::qrs_cmp_t s1;
      qrs_pkg::qrs_cmp_t s2;

      logic prev_below;
      logic gate;
      logic [2:0] valley;
      logic [2:0] setpt;

      logic [CW-1:0] on_cnt;
      logic [CW-1:0] off_cnt;
      logic [CW-1:0] ovp_cnt;
      logic [CW-1:0] sw_cnt;
      logic [CW-1:0] step_cnt;
      logic [CW-1:0] beb_cnt;

      logic seen_low;
      logic seen_high;
      logic seen_reset;
      logic burst;
      logic latched;

      logic en;
      logic [qrs_pkg::EV_W-1:0] status;
      logic [qrs_pkg::EV_W-1:0] mask;
      logic [7:0] cl_base;
      logic [7:0] line_start;
      logic [7:0] climit;
      logic [31:0] rdata;
      logic irq;
   } qrs_state_t;

   qrs_state_t st_ff;
   qrs_state_t nxt_st;
   qrs_pkg::qrs_cmp_t c;

   logic [CW-1:0] sup_len;
   logic sup_done;
   logic blank_done;
   logic turn_on;
   logic turn_off;
   logic on_max_hit;
   logic off_max_hit;
   logic step_end;
   logic burst_cond;

   logic [7:0] excess;
   logic [qrs_pkg::EV_W-1:0] ev;
   logic [qrs_pkg::EV_W-1:0] w1c;

   assign c = st_ff.s2;

   // ************************************************************
   // next-state logic
   // ************************************************************
   always_comb begin
      nxt_st = st_ff;
      ev = '0;

      // two flip-flop synchroniser on every comparator level
      nxt_st.s1 = cmp_in; // R18
      nxt_st.s2 = st_ff.s1; // R18
      nxt_st.prev_below = c.valley_below;

      // suppression length follows the sense level; a live choice tracks the ring decay
      sup_len = c.sup_sel_above ? CW'(P_SUP_SHORT) : CW'(P_SUP_LONG); // R5
      sup_done = st_ff.off_cnt >= sup_len; // R6
      off_max_hit = st_ff.off_cnt >= CW'(P_OFF_MAX - 1); // R8
      blank_done = st_ff.on_cnt >= CW'(P_LEB); // R10
      on_max_hit = st_ff.on_cnt >= CW'(P_ON_MAX - 1); // R11

      // on/off decisions; burst pulses and latch keep the gate low
      turn_on = !st_ff.gate && st_ff.en && !st_ff.latched && !st_ff.burst &&
                ((sup_done && st_ff.valley >= st_ff.setpt) || off_max_hit); // R7 R8
      turn_off = st_ff.gate && (!st_ff.en || st_ff.latched || on_max_hit ||
                 (blank_done && (c.pwm_trip || c.climit_trip))); // R9 R10 R11 R12

      if (turn_on) begin
         nxt_st.gate = 1'b1;
         nxt_st.on_cnt = '0;
         nxt_st.valley = qrs_pkg::VALLEY_MIN; // R3
         ev[qrs_pkg::EV_OFFMAX] = !(sup_done && st_ff.valley >= st_ff.setpt);
      end else if (turn_off) begin
         nxt_st.gate = 1'b0;
         nxt_st.off_cnt = '0;
         ev[qrs_pkg::EV_ONMAX] = on_max_hit;
         ev[qrs_pkg::EV_CLIMIT] = blank_done && c.climit_trip;
      end else if (st_ff.gate) begin
         nxt_st.on_cnt = st_ff.on_cnt + 1'b1;
      end else begin
         if (!off_max_hit) begin
            nxt_st.off_cnt = st_ff.off_cnt + 1'b1;
         end
         // falling crossing counts once, saturating at the top
         if (c.valley_below && !st_ff.prev_below && st_ff.valley != qrs_pkg::VALLEY_MAX) begin
            nxt_st.valley = st_ff.valley + 3'h1; // R1 R2
         end
      end

      // overvoltage watch during off-time
      if (!st_ff.gate && c.ovp_above) begin
         nxt_st.ovp_cnt = st_ff.ovp_cnt + 1'b1;
         if (st_ff.ovp_cnt >= CW'(P_OVP_BLANK - 1) && !st_ff.latched) begin
            nxt_st.latched = 1'b1; // R4
            ev[qrs_pkg::EV_OVP] = 1'b1;
         end
      end else begin
         nxt_st.ovp_cnt = '0;
      end

      // shorted winding watch during on-time; short spikes fall away
      if (st_ff.gate && !st_ff.burst && c.sw_trip) begin
         nxt_st.sw_cnt = st_ff.sw_cnt + 1'b1;
         if (st_ff.sw_cnt >= CW'(P_SW_BLANK - 1) && !st_ff.latched) begin
            nxt_st.latched = 1'b1; // R13
            ev[qrs_pkg::EV_SW] = 1'b1;
         end
      end else begin
         nxt_st.sw_cnt = '0;
      end

      // setpoint stepping on a fixed period from what feedback did in it
      step_end = st_ff.step_cnt >= CW'(P_STEP - 1);
      nxt_st.seen_low = st_ff.seen_low | c.fb_above_low;
      nxt_st.seen_high = st_ff.seen_high | c.fb_above_high;
      nxt_st.seen_reset = st_ff.seen_reset | c.fb_above_reset;
      if (step_end) begin
         nxt_st.step_cnt = '0;
         nxt_st.seen_low = 1'b0;
         nxt_st.seen_high = 1'b0;
         nxt_st.seen_reset = 1'b0;
         if (st_ff.seen_reset) begin
            nxt_st.setpt = qrs_pkg::SETPT_MIN; // R16
         end else if (st_ff.seen_high) begin
            if (st_ff.setpt != qrs_pkg::SETPT_MIN) begin
               nxt_st.setpt = st_ff.setpt - 3'h1; // R16
            end
         end else if (!st_ff.seen_low && st_ff.setpt != qrs_pkg::SETPT_MAX) begin
            nxt_st.setpt = st_ff.setpt + 3'h1; // R16
         end
      end else begin
         nxt_st.step_cnt = st_ff.step_cnt + 1'b1;
      end

      // burst entry needs both conditions for the whole blanking time
      burst_cond = c.fb_below_burst && st_ff.setpt == qrs_pkg::BURST_SETPT;
      if (st_ff.burst) begin
         nxt_st.beb_cnt = '0;
         if (c.burst_exit) begin
            nxt_st.burst = 1'b0;
            nxt_st.setpt = qrs_pkg::SETPT_MIN; // R17
            nxt_st.step_cnt = '0;
         end
      end else if (burst_cond) begin
         nxt_st.beb_cnt = st_ff.beb_cnt + 1'b1;
         if (st_ff.beb_cnt >= CW'(P_BEB - 1)) begin
            nxt_st.burst = 1'b1; // R15
            ev[qrs_pkg::EV_BURST] = 1'b1;
         end
      end else begin
         nxt_st.beb_cnt = '0;
      end

      // line correction: the excess over start lowers the limit, floor at zero
      excess = (c.line_code > st_ff.line_start) ? c.line_code - st_ff.line_start : 8'h00; // R14
      nxt_st.climit = (st_ff.cl_base > excess) ? st_ff.cl_base - excess : 8'h00; // R14

      // register writes; a status set in the clearing cycle survives
      w1c = '0;
      if (bus_in.wr) begin
         case (bus_in.addr)
            qrs_pkg::REG_CTRL: nxt_st.en = bus_in.wdata[qrs_pkg::CTRL_EN_BIT];
            qrs_pkg::REG_STATUS: w1c = bus_in.wdata[qrs_pkg::EV_W-1:0];
            qrs_pkg::REG_MASK: nxt_st.mask = bus_in.wdata[qrs_pkg::EV_W-1:0];
            qrs_pkg::REG_CL_BASE: nxt_st.cl_base = bus_in.wdata[7:0];
            qrs_pkg::REG_LINE_START: nxt_st.line_start = bus_in.wdata[7:0];
            default: ;
         endcase
      end

      nxt_st.status = (st_ff.status & ~w1c) | ev;
      nxt_st.irq = |(nxt_st.status & nxt_st.mask);

      // read data stands only in the cycle after the strobe
      nxt_st.rdata = 32'h0000_0000;
      if (bus_in.rd) begin
         case (bus_in.addr)
            qrs_pkg::REG_CTRL: nxt_st.rdata = {31'h0, st_ff.en};
            qrs_pkg::REG_STATUS: nxt_st.rdata = {26'h0, st_ff.status};
            qrs_pkg::REG_MASK: nxt_st.rdata = {26'h0, st_ff.mask};
            qrs_pkg::REG_STATE: nxt_st.rdata = {15'h0, st_ff.climit, st_ff.latched,
                                                st_ff.burst, st_ff.gate,
                                                st_ff.setpt, st_ff.valley};
            qrs_pkg::REG_CL_BASE: nxt_st.rdata = {24'h0, st_ff.cl_base};
            qrs_pkg::REG_LINE_START: nxt_st.rdata = {24'h0, st_ff.line_start};
            default: nxt_st.rdata = 32'h0000_0000;
         endcase
      end
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_ff <= '0;
         // the few fields whose reset value is not zero
         st_ff.setpt <= qrs_pkg::SETPT_MIN; // R17
         st_ff.cl_base <= qrs_pkg::CL_BASE_RST;
         st_ff.line_start <= qrs_pkg::LINE_START_RST;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign gate_drive_output = st_ff.gate;
   assign current_limit = st_ff.climit;
   assign burst_active = st_ff.burst;
   assign latched_off = st_ff.latched;
   assign rdata = st_ff.rdata;
   assign irq = st_ff.irq;

   // ************************************************************
   // checks
   // ************************************************************
   a_valley_clear: assert property (@(posedge clk) disable iff (!nrst) // R3
      $rose(st_ff.gate) |-> st_ff.valley == 3'h0)
      else $error("valley count not cleared at turn-on");

   a_valley_sat: assert property (@(posedge clk) disable iff (!nrst) // R1
      (st_ff.valley == 3'h7 && !turn_on) |=> st_ff.valley == 3'h7)
      else $error("valley count wrapped");

   a_sup_hold: assert property (@(posedge clk) disable iff (!nrst) // R6
      $rose(st_ff.gate) |-> $past(st_ff.off_cnt) >= CW'(P_SUP_SHORT))
      else $error("gate rose inside suppression");

   a_on_cause: assert property (@(posedge clk) disable iff (!nrst) // R7
      $rose(st_ff.gate) |-> ($past(st_ff.valley) >= $past(st_ff.setpt) ||
                             $past(st_ff.off_cnt) >= CW'(P_OFF_MAX - 1)))
      else $error("gate rose without cause");

   a_off_max: assert property (@(posedge clk) disable iff (!nrst || !ce) // R8
      (!st_ff.gate && st_ff.en && !st_ff.latched && !st_ff.burst &&
       st_ff.off_cnt >= CW'(P_OFF_MAX - 1)) |=> st_ff.gate)
      else $error("maximum off-time not enforced");

   a_leb_min: assert property (@(posedge clk) disable iff (!nrst) // R10
      ($fell(st_ff.gate) && $past(st_ff.en) && !$past(st_ff.latched)) |->
      $past(st_ff.on_cnt) >= CW'(P_LEB))
      else $error("pulse shorter than blanking");

   a_on_max: assert property (@(posedge clk) disable iff (!nrst) // R11
      st_ff.gate |-> st_ff.on_cnt < CW'(P_ON_MAX))
      else $error("maximum on-time exceeded");

   a_trip_off: assert property (@(posedge clk) disable iff (!nrst || !ce) // R9 R12
      (st_ff.gate && blank_done && (c.pwm_trip || c.climit_trip)) |=> !st_ff.gate)
      else $error("current trip did not end pulse");

   a_burst_entry: assert property (@(posedge clk) disable iff (!nrst) // R15
      $rose(st_ff.burst) |-> $past(st_ff.setpt) == 3'h7 && $past(c.fb_below_burst))
      else $error("burst entered without conditions");

   a_setpt_range: assert property (@(posedge clk) disable iff (!nrst) // R16
      st_ff.setpt >= 3'h1)
      else $error("setpoint below one");

   a_burst_exit: assert property (@(posedge clk) disable iff (!nrst) // R17
      $fell(st_ff.burst) |-> st_ff.setpt == 3'h1)
      else $error("setpoint not reset on burst exit");
endmodule : qrs_switch_timing
`default_nettype wire

// file: dv/qrs_stage_model.sv
// Purpose: behavioural comparator and power-stage model facing the switch timing block
// Assumes: bench sets valley spacing and trip kind, delay, width
// Notes: outputs change just after a rising edge
`timescale 1ns/100ps
`default_nettype none
module qrs_stage_model (
   // clock and gate
   input wire logic clk,
   input wire logic gate,
   // scenario knobs
   input wire logic [7:0] valley_per,
   input wire logic [1:0] trip_sel,
   input wire logic [7:0] trip_dly,
   input wire logic [7:0] trip_w,
   input wire logic sup_high,
   input wire logic ovp_on,
   // comparator levels
   output logic valley_below = 1'b0,
   output logic ovp_above = 1'b0,
   output logic sup_sel_above = 1'b0,
   output logic pwm_trip = 1'b0,
   output logic climit_trip = 1'b0,
   output logic sw_trip = 1'b0
);
   int on_n = 0;
   int off_n = 0;
   logic trip;
   // phase counters restart at every gate edge
   always_ff @(posedge clk) begin
      on_n <= gate ? on_n + 1 : 0;
      off_n <= gate ? 0 : off_n + 1;
   end
   // a narrow window models spikes, a wide one held faults
   assign trip = gate && (on_n >= trip_dly) && (on_n < trip_dly + trip_w);
   // ringing dips below valley level two cycles per period, off-time only
   always_ff @(posedge clk) begin
      valley_below <= !gate && (valley_per != 8'h00) && ((off_n % valley_per) >= valley_per - 2);
      ovp_above <= ovp_on && !gate; // clamped while the switch conducts
      sup_sel_above <= sup_high;
      pwm_trip <= trip && (trip_sel == 2'h1);
      climit_trip <= trip && (trip_sel == 2'h2);
      sw_trip <= trip && (trip_sel == 2'h3);
   end
endmodule : qrs_stage_model
`default_nettype wire

// file: dv/testbench.sv
// Purpose: self-checking bench for the switch timing block
// Assumes: stage model drives switching comparators; bench drives feedback, line code
// Notes: long counts shortened by parameters; limits derive from them
`timescale 1ns/100ps
`default_nettype none
module testbench;
   // ******
   // setup
   // ******
   localparam int P_LEB = 11;
   localparam int P_ON_MAX = 60;
   localparam int P_OFF_MAX = 300;
   localparam int P_SUP_SHORT = 20;
   localparam int P_SUP_LONG = 40;
   localparam int P_OVP_BLANK = 20;
   localparam int P_SW_BLANK = 10;
   localparam int P_STEP = 200;
   localparam int P_BEB = 100;
   localparam int T_MAX = 4000;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   qrs_pkg::qrs_bus_t bus = '0;
   logic fb_lo = 1'b1;
   logic fb_hi = 1'b0;
   logic fb_rst = 1'b0;
   logic fb_burst = 1'b0;
   logic b_exit = 1'b0;
   logic [7:0] line_code = 8'h00;
   logic [7:0] valley_per = 8'h00;
   logic [7:0] trip_dly = 8'h00;
   logic [7:0] trip_w = 8'hff;
   logic [1:0] trip_sel = 2'h1;
   logic sup_high = 1'b0;
   logic ovp_on = 1'b0;
   logic valley_below, ovp_above, sup_sel_above, pwm_trip, climit_trip, sw_trip;
   logic [31:0] rdata;
   logic [7:0] current_limit;
   logic irq, gate, burst_active, latched_off;
   int n_mismatch = 0;
   int n_compared = 0;
   wire qrs_pkg::qrs_cmp_t cmp = {valley_below, ovp_above, sup_sel_above, pwm_trip, climit_trip, sw_trip,
      fb_lo, fb_hi, fb_rst, fb_burst, b_exit, line_code};
   always #10 clk = ~clk;
   qrs_switch_timing #(.P_LEB(P_LEB), .P_ON_MAX(P_ON_MAX), .P_OFF_MAX(P_OFF_MAX), .P_SUP_SHORT(P_SUP_SHORT),
      .P_SUP_LONG(P_SUP_LONG), .P_OVP_BLANK(P_OVP_BLANK), .P_SW_BLANK(P_SW_BLANK), .P_STEP(P_STEP),
      .P_BEB(P_BEB)) u_qrs_switch_timing (.clk(clk), .nrst(nrst), .ce(1'b1), .cmp_in(cmp), .bus_in(bus),
      .rdata(rdata), .irq(irq), .gate_drive_output(gate), .current_limit(current_limit),
      .burst_active(burst_active), .latched_off(latched_off));
   qrs_stage_model u_qrs_stage_model (.clk(clk), .gate(gate), .valley_per(valley_per), .trip_sel(trip_sel),
      .trip_dly(trip_dly), .trip_w(trip_w), .sup_high(sup_high), .ovp_on(ovp_on), .valley_below(valley_below),
      .ovp_above(ovp_above), .sup_sel_above(sup_sel_above), .pwm_trip(pwm_trip), .climit_trip(climit_trip),
      .sw_trip(sw_trip));
   // ******
   // helpers
   // ******
   task automatic wrap_up();
      $display("mismatches %0d compared %0d", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_rng(input int got, input int lo, input int hi);
      n_compared++;
      if (got < lo || got > hi) begin
         n_mismatch++;
         $display("mismatch at %0t got %h exp %h to %h", $time, got, lo, hi);
      end
   endtask : chk_rng
   task automatic do_reset();
      @(posedge clk);
      nrst <= 1'b0;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
   endtask : do_reset
   // one-cycle strobes; read data stand in the next cycle only
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask : rd
   // counts cycles until gate shows v; a hang ends the run
   task automatic wait_lvl(input logic v, output int n);
      n = 0;
      while (gate !== v) begin
         @(posedge clk);
         #1 n++;
         if (n > T_MAX) begin
            n_mismatch++;
            wrap_up();
         end
      end
   endtask : wait_lvl
   task automatic meas(output int on_c, output int off_c);
      int n;
      wait_lvl(1'b0, n);
      wait_lvl(1'b1, n);
      wait_lvl(1'b0, on_c);
      wait_lvl(1'b1, off_c);
   endtask : meas
   // polls the setpoint; one that never arrives ends the run
   task automatic wait_st(input logic [2:0] v, input int lim);
      logic [31:0] d;
      for (int i = 0; i < lim; i++) begin
         rd(qrs_pkg::REG_STATE, d);
         if (d[5:3] === v) break;
      end
      chk(d[5:3], v);
      if (d[5:3] !== v) wrap_up();
   endtask : wait_st
   // ******
   // scenarios
   // ******
   task automatic t_regs();
      logic [31:0] d;
      rd(qrs_pkg::REG_STATE, d);
      chk(d[5:0], 6'h08);
      wr(8'hf0, 32'h5a);
      rd(8'hf0, d);
      chk(d, 32'h0);
      rd(qrs_pkg::REG_CL_BASE, d);
      chk(d, {24'h0, qrs_pkg::CL_BASE_RST});
      rd(qrs_pkg::REG_LINE_START, d);
      chk(d, {24'h0, qrs_pkg::LINE_START_RST});
      rd(qrs_pkg::REG_MASK, d);
      chk(d, 32'h0);
   endtask : t_regs
   task automatic t_valley();
      logic [31:0] d;
      @(posedge clk);
      valley_per <= 8'h08;
      repeat (120) @(posedge clk);
      rd(qrs_pkg::REG_STATE, d);
      chk(d[2:0], 3'h7);
   endtask : t_valley
   // early valleys wait out suppression, an early trip waits out blanking
   task automatic t_sup(input logic hi, input int exp);
      int on_c, off_c;
      @(posedge clk);
      sup_high <= hi;
      wr(qrs_pkg::REG_CTRL, 32'h1);
      meas(on_c, off_c);
      chk_rng(off_c, exp, exp + 4);
      chk_rng(on_c, P_LEB, P_LEB + 4);
   endtask : t_sup
   task automatic maximum_off_time();
      int on_c, off_c;
      logic [31:0] d;
      @(posedge clk);
      valley_per <= 8'h00;
      wr(qrs_pkg::REG_MASK, 32'h8);
      meas(on_c, off_c);
      chk_rng(off_c, P_OFF_MAX - 1, P_OFF_MAX + 2);
      repeat (2) @(posedge clk);
      #1 chk(irq, 1'b1);
      wr(qrs_pkg::REG_MASK, 32'h0);
      wr(qrs_pkg::REG_CTRL, 32'h0);
      rd(qrs_pkg::REG_STATUS, d);
      chk(d[3], 1'b1);
      chk(irq, 1'b0);
      wr(qrs_pkg::REG_MASK, 32'h8);
      wr(qrs_pkg::REG_STATUS, 32'h8);
      rd(qrs_pkg::REG_STATUS, d);
      chk(d[3], 1'b0);
      chk(irq, 1'b0);
   endtask : maximum_off_time
   task automatic maximum_on_time();
      int on_c, off_c;
      logic [31:0] d;
      @(posedge clk);
      trip_sel <= 2'h0;
      valley_per <= 8'h08;
      sup_high <= 1'b1;
      wr(qrs_pkg::REG_CTRL, 32'h1);
      meas(on_c, off_c);
      chk_rng(on_c, P_ON_MAX - 1, P_ON_MAX + 1);
      wait_lvl(1'b1, on_c);
      rd(qrs_pkg::REG_STATE, d);
      chk({d[6], d[2:0]}, 4'h8);
      rd(qrs_pkg::REG_STATUS, d);
      chk(d[4], 1'b1);
   endtask : maximum_on_time
   task automatic t_climit();
      int on_c, off_c;
      logic [31:0] d;
      @(posedge clk);
      trip_sel <= 2'h2;
      trip_dly <= 8'h1e;
      meas(on_c, off_c);
      chk_rng(on_c, 31, 36);
      rd(qrs_pkg::REG_STATUS, d);
      chk(d[5], 1'b1);
   endtask : t_climit
   task automatic t_line();
      @(posedge clk);
      line_code <= 8'h50;
      repeat (8) @(posedge clk);
      #1 chk(current_limit, 8'hef);
      wr(qrs_pkg::REG_CL_BASE, 32'h30);
      @(posedge clk);
      line_code <= 8'h90;
      repeat (8) @(posedge clk);
      #1 chk(current_limit, 8'h00);
      wr(qrs_pkg::REG_CL_BASE, 32'hff);
      @(posedge clk);
      line_code <= 8'h00;
   endtask : t_line
   task automatic t_setpt();
      int n;
      logic [31:0] d;
      @(posedge clk);
      fb_lo <= 1'b0;
      wait_st(3'h7, 8 * P_STEP);
      @(posedge clk);
      fb_burst <= 1'b1;
      n = 0;
      while (burst_active !== 1'b1 && n < T_MAX) begin
         @(posedge clk);
         #1 n++;
      end
      chk_rng(n, P_BEB, P_BEB + 5);
      if (n >= T_MAX) wrap_up();
      @(posedge clk);
      b_exit <= 1'b1;
      repeat (6) @(posedge clk);
      #1 chk(burst_active, 1'b0);
      rd(qrs_pkg::REG_STATE, d);
      chk(d[5:3], 3'h1);
      rd(qrs_pkg::REG_STATUS, d);
      chk(d[2], 1'b1);
      @(posedge clk);
      b_exit <= 1'b0;
      fb_burst <= 1'b0;
      wait_st(3'h4, 4 * P_STEP);
      @(posedge clk);
      fb_hi <= 1'b1;
      fb_lo <= 1'b1;
      wait_st(3'h3, P_STEP);
      @(posedge clk);
      fb_rst <= 1'b1;
      wait_st(3'h1, (P_STEP + 20) / 2);
      @(posedge clk);
      fb_hi <= 1'b0;
      fb_rst <= 1'b0;
   endtask : t_setpt
   // a short spike is ignored, a held one latches off
   task automatic t_sw();
      int on_c, off_c;
      logic [31:0] d;
      @(posedge clk);
      trip_sel <= 2'h3;
      trip_dly <= 8'h0c;
      trip_w <= 8'(P_SW_BLANK / 2);
      meas(on_c, off_c);
      chk(latched_off, 1'b0);
      @(posedge clk);
      trip_w <= 8'(4 * P_SW_BLANK);
      repeat (200) @(posedge clk);
      #1 chk({latched_off, gate}, 2'h2);
      rd(qrs_pkg::REG_STATUS, d);
      chk(d[1], 1'b1);
   endtask : t_sw
   task automatic t_ovp();
      @(posedge clk);
      trip_sel <= 2'h1;
      ovp_on <= 1'b1;
      repeat (P_OVP_BLANK - 5) @(posedge clk);
      #1 chk(latched_off, 1'b0);
      repeat (15) @(posedge clk);
      #1 chk(latched_off, 1'b1);
   endtask : t_ovp
   // latch scenarios run last: only reset clears the latch
   initial begin
      do_reset();
      t_regs();
      t_valley();
      t_sup(1'b1, P_SUP_SHORT);
      t_sup(1'b0, P_SUP_LONG);
      maximum_off_time();
      maximum_on_time();
      t_climit();
      t_line();
      t_setpt();
      t_sw();
      do_reset();
      t_ovp();
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
